// *** spdc_pkg.sv ***
package spdc_pkg;

    localparam int VEC_W      = 128;
    localparam int VEC_DEPTH  = 16;
    localparam int VEC_IDX_W  = 4;
    localparam int PI_W       = 64;
    localparam int PI_DEPTH   = 8;
    localparam int PI_IDX_W   = 3;
    localparam int GPR_W      = 64;
    localparam int GPR_DEPTH  = 16;
    localparam int LANE_W     = 32;
    localparam int LANES      = 4;
    localparam int BYTE_W     = 8;
    localparam int PI_BYTES   = 8;
    localparam int CSR_W      = 32;
    localparam int FLAG_W     = 32;

    localparam logic [CSR_W-1:0]  CSR_RESET     = 32'h0000_1F80;
    localparam logic [CSR_W-1:0]  CSR_WRITABLE  = 32'h0000_FFFF;
    localparam logic [FLAG_W-1:0] FLAGS_RESET   = 32'h0000_0002;
    localparam logic [FLAG_W-1:0] FLAGS_CMP_CLR = 32'h0000_08D5;

    localparam int FLAG_CF = 0;
    localparam int FLAG_PF = 2;
    localparam int FLAG_ZF = 6;

    localparam logic [31:0] FEATURE_LEAF    = 32'h0000_0001;
    localparam int          FEATURE_VEC_BIT = 25;

    localparam int SP_SIGN   = 31;
    localparam int SP_EXP_HI = 30;
    localparam int SP_EXP_LO = 23;
    localparam int SP_MAN_HI = 22;

    localparam logic [GPR_W-1:0] ADDR16_MASK = 64'h0000_0000_0000_FFFF;
    localparam logic [GPR_W-1:0] ADDR32_MASK = 64'h0000_0000_FFFF_FFFF;
    localparam logic [GPR_W-1:0] ADDR64_MASK = 64'hFFFF_FFFF_FFFF_FFFF;

    typedef enum logic [1:0] {MODE_REAL, MODE_PROT, MODE_V86, MODE_LONG} spdc_mode_t;
    typedef enum logic [2:0] {SEG_ES, SEG_CS, SEG_SS, SEG_DS, SEG_FS, SEG_GS} spdc_seg_t;
    typedef enum logic [1:0] {AW_16, AW_32, AW_64} spdc_aw_t;

    typedef enum logic [3:0] {
        OP_NOP,
        OP_PI_ADD,
        OP_PI_TO_VEC,
        OP_VEC_TO_PI,
        OP_PS_AND,
        OP_PS_OR,
        OP_PS_XOR,
        OP_PS_MOV,
        OP_SS_MOV,
        OP_SS_CMP,
        OP_LD_CSR,
        OP_ST_CSR,
        OP_FENCE,
        OP_FEATURE
    } spdc_op_t;

    typedef struct packed {
        logic      addr_size;
        logic      op_size;
        logic      rep;
        logic      repne;
        logic      lock;
        logic      seg_en;
        spdc_seg_t seg;
    } spdc_prefix_t;

    typedef struct packed {
        spdc_op_t              op;
        spdc_mode_t            mode;
        spdc_prefix_t          pfx;
        logic                  has_mem;
        logic [VEC_IDX_W-1:0]  dst;
        logic [VEC_IDX_W-1:0]  src;
        logic                  base_en;
        logic [VEC_IDX_W-1:0]  base_idx;
        logic                  index_en;
        logic [VEC_IDX_W-1:0]  index_idx;
        logic [1:0]            scale;
        logic [31:0]           disp;
        logic [VEC_W-1:0]      mem_data;
        logic [31:0]           leaf;
    } spdc_instr_t;

    typedef struct packed {
        logic      ud;
        logic      reserved;
        spdc_aw_t  aw;
        spdc_seg_t seg;
    } spdc_chk_t;

    typedef struct packed {
        logic             valid;
        logic             is_store;
        spdc_seg_t        seg;
        logic [GPR_W-1:0] addr;
        logic [CSR_W-1:0] data;
    } spdc_access_t;

    typedef logic [GPR_DEPTH-1:0][GPR_W-1:0] spdc_gpr_file_t;

endpackage : spdc_pkg

// *** spdc_regmem.sv ***
`timescale 1ns/100ps
module spdc_regmem #(
    parameter int W     = 128,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic          i_sys_clk,
    input  wire logic          i_rst_n,
    input  wire logic          i_we,
    input  wire logic [AW-1:0] i_waddr,
    input  wire logic [W-1:0]  i_wdata,
    input  wire logic [AW-1:0] i_raddr0,
    input  wire logic [AW-1:0] i_raddr1,
    output logic      [W-1:0]  o_rdata0,
    output logic      [W-1:0]  o_rdata1
);
    logic [W-1:0] mem [DEPTH];

    // Contents are left undefined at reset, as architectural registers are.
    always_ff @(posedge i_sys_clk)
    begin
        if (i_we)
        begin
            mem[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            o_rdata0 <= '0;
            o_rdata1 <= '0;
        end
        else
        begin
            o_rdata0 <= mem[i_raddr0];
            o_rdata1 <= mem[i_raddr1];
        end
    end
endmodule : spdc_regmem

// *** spdc_prefix_chk.sv ***
`timescale 1ns/100ps
module spdc_prefix_chk (
    input  spdc_pkg::spdc_instr_t i_instr,
    output spdc_pkg::spdc_chk_t   o_chk
);
    import spdc_pkg::*;

    logic     pi_op;
    logic     res_mem;
    logic     res_pi;
    spdc_aw_t def_aw;
    spdc_aw_t alt_aw;

    always_comb
    begin
        pi_op   = (i_instr.op == OP_PI_ADD) || (i_instr.op == OP_PI_TO_VEC)
                  || (i_instr.op == OP_VEC_TO_PI);
        // Without a memory operand the 2EH/3EH bytes are hints and also reserved.
        res_mem = (i_instr.pfx.addr_size || i_instr.pfx.seg_en) && !i_instr.has_mem;
        res_pi  = i_instr.pfx.op_size || i_instr.pfx.rep || i_instr.pfx.repne;
        o_chk.ud       = pi_op && i_instr.pfx.lock;
        o_chk.reserved = pi_op && (res_mem || res_pi);
        case (i_instr.mode)
            MODE_LONG:
            begin
                def_aw = AW_64;
                alt_aw = AW_32;
            end
            MODE_PROT:
            begin
                def_aw = AW_32;
                alt_aw = AW_16;
            end
            default:
            begin
                def_aw = AW_16;
                alt_aw = AW_32;
            end
        endcase
        o_chk.aw  = (i_instr.has_mem && i_instr.pfx.addr_size) ? alt_aw : def_aw;
        o_chk.seg = (i_instr.has_mem && i_instr.pfx.seg_en) ? i_instr.pfx.seg : SEG_DS;
    end
endmodule : spdc_prefix_chk

// *** spdc_core.sv ***
`timescale 1ns/100ps
module spdc_core (
    input  wire logic                       i_sys_clk,
    input  wire logic                       i_rst_n,
    input  wire logic                       i_valid,
    input  spdc_pkg::spdc_instr_t           i_instr,
    input  spdc_pkg::spdc_gpr_file_t        i_gpr,
    input  wire logic                       i_stores_drained,
    output logic                            o_ready,
    output logic                            o_done,
    output logic                            o_ud,
    output logic                            o_reserved,
    output spdc_pkg::spdc_access_t          o_access,
    output logic [spdc_pkg::VEC_W-1:0]      o_result,
    output logic [spdc_pkg::FLAG_W-1:0]     o_flags,
    output logic [spdc_pkg::CSR_W-1:0]      o_csr,
    output logic [31:0]                     o_feature_edx,
    output logic                            o_fence_busy
);
    import spdc_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_FENCE} spdc_state_t;

    spdc_state_t           state;
    spdc_state_t           next_state;
    spdc_instr_t           instr;
    spdc_instr_t           next_instr;
    spdc_chk_t             chk;
    logic                  next_ready;
    logic                  next_done;
    logic                  next_ud;
    logic                  next_reserved;
    spdc_access_t          next_access;
    logic [VEC_W-1:0]      next_result;
    logic [FLAG_W-1:0]     flags;
    logic [FLAG_W-1:0]     next_flags;
    logic [CSR_W-1:0]      csr;
    logic [CSR_W-1:0]      next_csr;
    logic [31:0]           next_feature_edx;
    logic                  next_fence_busy;
    logic                  vec_we;
    logic [VEC_IDX_W-1:0]  vec_waddr;
    logic [VEC_W-1:0]      vec_wdata;
    logic [VEC_W-1:0]      vec_rd0;
    logic [VEC_W-1:0]      vec_rd1;
    logic                  pi_we;
    logic [PI_IDX_W-1:0]   pi_waddr;
    logic [PI_W-1:0]       pi_wdata;
    logic [PI_W-1:0]       pi_rd0;
    logic [PI_W-1:0]       pi_rd1;
    logic [VEC_W-1:0]      vsrc;
    logic [PI_W-1:0]       psrc;
    logic [VEC_W-1:0]      ps_res;
    logic [PI_W-1:0]       pi_sum;
    logic [GPR_W-1:0]      ea_raw;
    logic [GPR_W-1:0]      ea;
    logic [1:0]            cmp;
    logic                  cmp_unord;
    // Outside 64-bit mode the extension bit of a register index is dropped.
    function automatic logic [VEC_IDX_W-1:0] f_vidx(input logic [VEC_IDX_W-1:0] idx,
                                                  input spdc_mode_t mode);
        return (mode == MODE_LONG) ? idx : {1'b0, idx[VEC_IDX_W-2:0]};
    endfunction : f_vidx

    function automatic logic f_nan(input logic [LANE_W-1:0] v);
        return (&v[SP_EXP_HI:SP_EXP_LO]) && (|v[SP_MAN_HI:0]);
    endfunction : f_nan

    // Returns {less, equal}; plus and minus zero compare equal.
    function automatic logic [1:0] f_cmp(input logic [LANE_W-1:0] a,
                                         input logic [LANE_W-1:0] b);
        logic lt;
        logic eq;
        lt = 1'b0;
        eq = (a == b) || ((a[SP_EXP_HI:0] == '0) && (b[SP_EXP_HI:0] == '0));
        if (!eq && (a[SP_SIGN] != b[SP_SIGN]))
        begin
            lt = a[SP_SIGN];
        end
        else if (!eq)
        begin
            lt = a[SP_SIGN] ? (a[SP_EXP_HI:0] > b[SP_EXP_HI:0])
                            : (a[SP_EXP_HI:0] < b[SP_EXP_HI:0]);
        end
        return {lt, eq};
    endfunction : f_cmp

    spdc_prefix_chk u_chk (
        .i_instr (instr),
        .o_chk   (chk)
    );

    spdc_regmem #(
        .W     (VEC_W),
        .DEPTH (VEC_DEPTH),
        .AW    (VEC_IDX_W)
    ) u_vec_regs (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_we      (vec_we),
        .i_waddr   (vec_waddr),
        .i_wdata   (vec_wdata),
        .i_raddr0  (f_vidx(i_instr.dst, i_instr.mode)),
        .i_raddr1  (f_vidx(i_instr.src, i_instr.mode)),
        .o_rdata0  (vec_rd0),
        .o_rdata1  (vec_rd1)
    );

    spdc_regmem #(
        .W     (PI_W),
        .DEPTH (PI_DEPTH),
        .AW    (PI_IDX_W)
    ) u_pi_regs (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_we      (pi_we),
        .i_waddr   (pi_waddr),
        .i_wdata   (pi_wdata),
        .i_raddr0  (i_instr.dst[PI_IDX_W-1:0]),
        .i_raddr1  (i_instr.src[PI_IDX_W-1:0]),
        .o_rdata0  (pi_rd0),
        .o_rdata1  (pi_rd1)
    );

    assign vsrc = instr.has_mem ? instr.mem_data : vec_rd1;
    assign psrc = instr.has_mem ? instr.mem_data[PI_W-1:0] : pi_rd1;

    generate
        for (genvar l = 0; l < LANES; l++)
        begin : g_lane
            logic [LANE_W-1:0] lane_a;
            logic [LANE_W-1:0] lane_b;
            assign lane_a = vec_rd0[l*LANE_W +: LANE_W];
            assign lane_b = vsrc[l*LANE_W +: LANE_W];
            assign ps_res[l*LANE_W +: LANE_W] = (instr.op == OP_PS_AND) ? (lane_a & lane_b)
                                              : (instr.op == OP_PS_OR)  ? (lane_a | lane_b)
                                              : (instr.op == OP_PS_XOR) ? (lane_a ^ lane_b)
                                              : lane_b;
        end
        for (genvar b = 0; b < PI_BYTES; b++)
        begin : g_byte
            assign pi_sum[b*BYTE_W +: BYTE_W] = pi_rd0[b*BYTE_W +: BYTE_W]
                                              + psrc[b*BYTE_W +: BYTE_W];
        end
    endgenerate

    // The address is built from general registers and displacement only.
    always_comb
    begin
        ea_raw = (instr.base_en ? i_gpr[instr.base_idx] : '0)
               + (instr.index_en ? (i_gpr[instr.index_idx] << instr.scale) : '0)
               + {{(GPR_W-32){instr.disp[31]}}, instr.disp};
        case (chk.aw)
            AW_16:   ea = ea_raw & ADDR16_MASK;
            AW_32:   ea = ea_raw & ADDR32_MASK;
            default: ea = ea_raw & ADDR64_MASK;
        endcase
        cmp       = f_cmp(vec_rd0[LANE_W-1:0], vsrc[LANE_W-1:0]);
        cmp_unord = f_nan(vec_rd0[LANE_W-1:0]) || f_nan(vsrc[LANE_W-1:0]);
    end

    always_comb
    begin
        next_state       = state;
        next_instr       = instr;
        next_done        = 1'b0;
        next_ud          = 1'b0;
        next_reserved    = 1'b0;
        next_access      = '0;
        next_result      = o_result;
        next_flags       = flags;
        next_csr         = csr;
        next_feature_edx = o_feature_edx;
        vec_we           = 1'b0;
        vec_waddr        = f_vidx(instr.dst, instr.mode);
        vec_wdata        = ps_res;
        pi_we            = 1'b0;
        pi_waddr         = instr.dst[PI_IDX_W-1:0];
        pi_wdata         = pi_sum;
        case (state)
            ST_IDLE:
            begin
                if (i_valid)
                begin
                    next_instr = i_instr;
                    next_state = ST_EXEC;
                end
            end
            ST_EXEC:
            begin
                next_state    = ST_IDLE;
                next_done     = 1'b1;
                next_reserved = chk.reserved;
                if (chk.ud)
                begin
                    next_ud = 1'b1;
                end
                else
                begin
                    // Reserved prefixes fall through here untouched.
                    next_access.valid = instr.has_mem && (instr.op != OP_FENCE)
                                        && (instr.op != OP_FEATURE);
                    next_access.seg   = chk.seg;
                    next_access.addr  = ea;
                    case (instr.op)
                        OP_PI_ADD:
                        begin
                            pi_we       = 1'b1;
                            next_result = {{(VEC_W-PI_W){1'b0}}, pi_sum};
                        end
                        OP_PI_TO_VEC:
                        begin
                            vec_we      = 1'b1;
                            vec_wdata   = {vec_rd0[VEC_W-1:PI_W], psrc};
                            next_result = vec_wdata;
                        end
                        OP_VEC_TO_PI:
                        begin
                            pi_we       = 1'b1;
                            pi_wdata    = vsrc[PI_W-1:0];
                            next_result = {{(VEC_W-PI_W){1'b0}}, vsrc[PI_W-1:0]};
                        end
                        OP_PS_AND, OP_PS_OR, OP_PS_XOR, OP_PS_MOV:
                        begin
                            vec_we      = 1'b1;
                            next_result = ps_res;
                        end
                        OP_SS_MOV:
                        begin
                            vec_we      = 1'b1;
                            vec_wdata   = {vec_rd0[VEC_W-1:LANE_W], vsrc[LANE_W-1:0]};
                            next_result = vec_wdata;
                        end
                        OP_SS_CMP:
                        begin
                            next_flags          = flags & ~FLAGS_CMP_CLR;
                            next_flags[FLAG_ZF] = cmp_unord || cmp[0];
                            next_flags[FLAG_PF] = cmp_unord;
                            next_flags[FLAG_CF] = cmp_unord || cmp[1];
                        end
                        OP_LD_CSR:
                        begin
                            // Reserved upper bits stay zero whatever is loaded.
                            next_csr = vsrc[CSR_W-1:0] & CSR_WRITABLE;
                        end
                        OP_ST_CSR:
                        begin
                            next_access.is_store = 1'b1;
                            next_access.data     = csr;
                        end
                        OP_FEATURE:
                        begin
                            next_feature_edx = '0;
                            next_feature_edx[FEATURE_VEC_BIT] = (instr.leaf == FEATURE_LEAF);
                        end
                        OP_FENCE:
                        begin
                            next_done  = i_stores_drained;
                            next_state = i_stores_drained ? ST_IDLE : ST_FENCE;
                        end
                        default:
                        begin
                            next_result = o_result;
                        end
                    endcase
                end
            end
            ST_FENCE:
            begin
                // Nothing new is taken while earlier stores are in flight.
                if (i_stores_drained)
                begin
                    next_done  = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
        next_ready      = (next_state == ST_IDLE);
        next_fence_busy = (next_state == ST_FENCE);
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            state         <= ST_IDLE;
            instr         <= '0;
            o_ready       <= 1'b0;
            o_done        <= 1'b0;
            o_ud          <= 1'b0;
            o_reserved    <= 1'b0;
            o_access      <= '0;
            o_result      <= '0;
            flags         <= FLAGS_RESET;
            csr           <= CSR_RESET;
            o_feature_edx <= '0;
            o_fence_busy  <= 1'b0;
        end
        else
        begin
            state         <= next_state;
            instr         <= next_instr;
            o_ready       <= next_ready;
            o_done        <= next_done;
            o_ud          <= next_ud;
            o_reserved    <= next_reserved;
            o_access      <= next_access;
            o_result      <= next_result;
            flags         <= next_flags;
            csr           <= next_csr;
            o_feature_edx <= next_feature_edx;
            o_fence_busy  <= next_fence_busy;
        end
    end

    assign o_flags = flags;
    assign o_csr   = csr;
endmodule : spdc_core

// *** spdc_checker.sv ***
`timescale 1ns/100ps
module spdc_checker
    import spdc_pkg::*;
(
    input  wire logic           i_sys_clk,
    input  wire logic           i_rst_n,
    input  wire logic           i_valid,
    input  spdc_pkg::spdc_instr_t  i_instr,
    input  wire logic           i_stores_drained,
    input  wire logic           o_ready,
    input  wire logic           o_done,
    input  wire logic           o_ud,
    input  wire logic           o_reserved,
    input  spdc_pkg::spdc_access_t o_access,
    input  wire logic [31:0]    o_feature_edx,
    input  wire logic           o_fence_busy
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);
    wire pi = i_instr.op inside {OP_PI_ADD, OP_PI_TO_VEC, OP_VEC_TO_PI};
    wire lk = i_instr.pfx.lock;
    wire pf = i_instr.pfx.op_size || i_instr.pfx.rep || i_instr.pfx.repne;
    wire am = i_instr.pfx.addr_size || i_instr.pfx.seg_en;
    wire leaf1 = i_instr.leaf == FEATURE_LEAF;
    sequence s_take;
        o_ready && i_valid;
    endsequence
    sequence s_ans;
        ##2 o_done;
    endsequence
    property p_lock;
        s_take ##0 (pi && lk) |-> s_ans ##0 o_ud;
    endproperty
    a_lock: assert property (p_lock) else $error("lock did not fault");
    property p_udq;
        o_ud |-> o_done && !o_access.valid;
    endproperty
    a_udq: assert property (p_udq) else $error("fault with access");
    property p_rsv;
        s_take ##0 (pi && !lk && pf) |-> s_ans ##0 (o_reserved && !o_ud);
    endproperty
    a_rsv: assert property (p_rsv) else $error("prefix not reserved");
    property p_nomem;
        s_take ##0 (pi && !lk && !i_instr.has_mem && am) |-> s_ans ##0 o_reserved;
    endproperty
    a_nomem: assert property (p_nomem) else $error("no-memory prefix not reserved");
    property p_clean;
        s_take ##0 !pi |-> ##2 !(o_ud || o_reserved);
    endproperty
    a_clean: assert property (p_clean) else $error("flag on vector op");
    property p_feat;
        s_take ##0 (i_instr.op == OP_FEATURE) |->
            s_ans ##0 (o_feature_edx[FEATURE_VEC_BIT] == $past(leaf1, 2));
    endproperty
    a_feat: assert property (p_feat) else $error("feature bit wrong");
    property p_mode;
        s_take ##0 (i_instr.op != OP_FENCE) |-> s_ans;
    endproperty
    a_mode: assert property (p_mode) else $error("no completion");
    property p_fence;
        o_fence_busy && !i_stores_drained |=> !o_done;
    endproperty
    a_fence: assert property (p_fence) else $error("fence ended early");
    property p_drain;
        o_fence_busy && i_stores_drained |-> ##[1:2] o_done;
    endproperty
    a_drain: assert property (p_drain) else $error("fence never ended");
endmodule : spdc_checker

// *** spdc_tb.sv ***
`timescale 1ns/100ps
module testbench;
    import spdc_pkg::*;
    localparam logic [127:0] VA = {4{32'hA5A5_0001}};
    localparam logic [127:0] VB = {4{32'h5A5A_0002}};
    logic i_sys_clk, i_rst_n, i_valid, i_stores_drained, ud, rsv;
    logic o_ready, o_done, o_ud, o_reserved, o_fence_busy;
    logic [127:0] o_result;
    logic [31:0] o_flags, o_csr, o_feature_edx;
    spdc_instr_t i_instr;
    spdc_gpr_file_t i_gpr;
    spdc_access_t o_access, acc;
    int num_errors = 0;
    int checked = 0;
    spdc_core spdc_core_i (.i_sys_clk, .i_rst_n, .i_valid, .i_instr, .i_gpr,
        .i_stores_drained, .o_ready, .o_done, .o_ud, .o_reserved, .o_access,
        .o_result, .o_flags, .o_csr, .o_feature_edx, .o_fence_busy);
    task automatic chk(string nm, logic [127:0] exp, logic [127:0] got);
        checked++;
        if (got !== exp)
        begin
            $display("FAIL %s expected %h seen %h", nm, exp, got);
            num_errors++;
        end
    endtask : chk
    task automatic set(spdc_op_t op, spdc_mode_t m);
        i_instr = '0;
        i_instr.op = op;
        i_instr.mode = m;
    endtask : set
    // Inputs move 5 ns after each rising edge, so waits of whole periods keep that phase.
    task automatic wt;
        for (int n = 0; n < 40 && o_done !== 1'h1; n++) #50;
        chk("done", 1'h1, o_done);
        ud = o_ud;
        rsv = o_reserved;
        acc = o_access;
    endtask : wt
    task automatic go;
        i_valid = 1'h1;
        #50;
        i_valid = 1'h0;
        wt();
    endtask : go
    task automatic t_csr;
        set(OP_LD_CSR, MODE_REAL);
        i_instr.has_mem = 1'h1;
        i_instr.mem_data = 128'hABCD_1234;
        go();
        chk("csr_ld", 32'h0000_1234, o_csr);
        set(OP_ST_CSR, MODE_V86);
        i_instr.has_mem = 1'h1;
        go();
        chk("st", 1'h1, acc.is_store);
        chk("st_data", 32'h0000_1234, acc.data);
    endtask : t_csr
    task automatic t_lock;
        set(OP_PI_ADD, MODE_PROT);
        i_instr.pfx.lock = 1'h1;
        go();
        chk("ud", 1'h1, ud);
        chk("acc", 1'h0, acc.valid);
        i_instr.op = OP_PS_AND;
        go();
        chk("ud_ps", 1'h0, ud);
    endtask : t_lock
    task automatic t_rsv;
        for (int i = 0; i < 5; i++)
        begin
            set(OP_PI_ADD, MODE_PROT);
            i_instr.pfx.seg = SEG_CS;
            {i_instr.pfx.op_size, i_instr.pfx.rep, i_instr.pfx.repne,
             i_instr.pfx.addr_size, i_instr.pfx.seg_en} = 5'h10 >> i;
            go();
            chk("rsv", 1'h1, rsv);
            chk("ud", 1'h0, ud);
        end
    endtask : t_rsv
    task automatic t_addr;
        set(OP_PI_ADD, MODE_PROT);
        i_instr.has_mem = 1'h1;
        i_instr.base_en = 1'h1;
        i_instr.base_idx = 4'h2;
        i_instr.disp = 32'h0000_0010;
        go();
        chk("addr32", 64'h0000_0000_9ABC_DF00, acc.addr);
        chk("acc_valid", 1'h1, acc.valid);
        chk("seg_ds", SEG_DS, acc.seg);
        i_instr.pfx.addr_size = 1'h1;
        i_instr.pfx.seg_en = 1'h1;
        i_instr.pfx.seg = SEG_FS;
        go();
        chk("addr16", 64'h0000_0000_0000_DF00, acc.addr);
        chk("seg_fs", SEG_FS, acc.seg);
        chk("rsv_mem", 1'h0, rsv);
    endtask : t_addr
    task automatic t_feat;
        for (int m = 0; m < 4; m++)
        begin
            set(OP_FEATURE, spdc_mode_t'(m));
            i_instr.leaf = 32'h0000_0001;
            go();
            chk("feat1", 1'h1, o_feature_edx[FEATURE_VEC_BIT]);
            i_instr.leaf = 32'h0000_0002;
            go();
            chk("feat2", 1'h0, o_feature_edx[FEATURE_VEC_BIT]);
        end
    endtask : t_feat
    task automatic t_vec;
        set(OP_PS_MOV, MODE_LONG);
        i_instr.has_mem = 1'h1;
        i_instr.dst = 4'h9;
        i_instr.mem_data = VA;
        go();
        i_instr.dst = 4'h1;
        i_instr.mem_data = VB;
        go();
        i_instr.has_mem = 1'h0;
        i_instr.dst = 4'h2;
        i_instr.src = 4'h9;
        go();
        chk("vec16", VA, o_result);
        i_instr.mode = MODE_PROT;
        go();
        chk("vec8", VB, o_result);
    endtask : t_vec
    task automatic t_cmp;
        set(OP_PS_MOV, MODE_PROT);
        i_instr.has_mem = 1'h1;
        i_instr.dst = 4'h3;
        i_instr.mem_data = {VA[127:32], 32'h3F80_0000};
        go();
        i_instr.dst = 4'h4;
        i_instr.mem_data = {VB[127:32], 32'h3F80_0000};
        go();
        i_instr.dst = 4'h5;
        i_instr.mem_data[31:0] = 32'h4000_0000;
        go();
        set(OP_SS_CMP, MODE_PROT);
        i_instr.dst = 4'h3;
        i_instr.src = 4'h4;
        go();
        chk("eq", 32'h0000_0042, o_flags);
        i_instr.src = 4'h5;
        go();
        chk("lt", 32'h0000_0003, o_flags);
    endtask : t_cmp
    task automatic t_fence;
        set(OP_FENCE, MODE_PROT);
        i_stores_drained = 1'h0;
        i_valid = 1'h1;
        #50;
        i_valid = 1'h0;
        #200;
        chk("busy", 1'h1, o_fence_busy);
        chk("held", 1'h0, o_done);
        i_stores_drained = 1'h1;
        wt();
    endtask : t_fence
    task automatic test_done;
        $display("checked %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done
    initial
    begin
        i_sys_clk = 1'h0;
        forever #25 i_sys_clk = ~i_sys_clk;
    end
    initial
    begin
        #100000;
        num_errors++;
        test_done();
    end
    initial
    begin
        i_rst_n = 1'h0;
        i_valid = 1'h0;
        i_stores_drained = 1'h1;
        i_instr = '0;
        i_gpr = '0;
        i_gpr[2] = 64'h1234_5678_9ABC_DEF0;
        repeat (6) @(posedge i_sys_clk);
        #5;
        i_rst_n = 1'h1;
        #100;
        chk("csr_rst", 32'h0000_1F80, o_csr);
        chk("flags_rst", 32'h0000_0002, o_flags);
        chk("ready_rst", 1'h1, o_ready);
        t_csr();
        t_lock();
        t_rsv();
        t_addr();
        t_feat();
        t_vec();
        t_cmp();
        t_fence();
        test_done();
    end
endmodule : testbench
bind spdc_core spdc_checker spdc_checker_i (.i_sys_clk, .i_rst_n, .i_valid, .i_instr,
    .i_stores_drained, .o_ready, .o_done, .o_ud, .o_reserved, .o_access,
    .o_feature_edx, .o_fence_busy);
